// ===== verilog/dfs_sequencer.sv
// Defrost, drain-heater, hot-gas valve and evaporator fan sequencer
`timescale 1ns/10ps
`include "dfs_regs.svh"
module dfs_sequencer (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                clk_en,
   input  wire logic                time_tick,
   input  wire logic                cool_demand,
   input  wire logic                defrost_start_req,
   input  wire logic                defrost_end_req,
   input  wire logic [1:0]          display_lock_select,
   input  wire logic [1:0]          defrost_type_select,
   input  wire logic [3:0]          aux_output_function,
   input  wire logic                drain_heater_enable,
   input  wire logic                fans_during_defrost,
   input  wire logic                evap_probe_valid,
   input  wire logic signed [15:0]  cabinet_probe,
   input  wire logic signed [15:0]  evaporator_probe,
   input  wire logic signed [15:0]  display_lock_value,
   input  wire logic signed [15:0]  setpoint,
   input  wire logic signed [15:0]  differential,
   input  wire logic signed [15:0]  fan_high_temp_cutoff,
   input  wire logic signed [15:0]  fan_low_temp_cutoff,
   input  wire logic signed [15:0]  fan_cutoff_hysteresis,
   input  wire logic [`DFS_TW-1:0]  post_defrost_alarm_disable_time,
   input  wire logic [`DFS_TW-1:0]  pre_defrost_time,
   input  wire logic [`DFS_TW-1:0]  post_defrost_heater_time,
   input  wire logic [`DFS_TW-1:0]  defrost_max_duration,
   input  wire logic [`DFS_TW-1:0]  dripping_time,
   input  wire logic [`DFS_TW-1:0]  power_on_output_delay,
   input  wire logic [`DFS_TW-1:0]  liquid_valve_start_delay,
   input  wire logic [`DFS_TW-1:0]  evacuation_delay,
   input  wire logic [`DFS_TW-1:0]  post_defrost_fan_delay,
   input  wire logic [`DFS_TW-1:0]  fan_on_time_comp_off,
   input  wire logic [`DFS_TW-1:0]  fan_off_time_comp_off,
   output logic                     compressor_output,
   output logic                     defrost_output,
   output logic                     drain_heater_output,
   output logic                     auxiliary_output,
   output logic                     fan_output,
   output logic                     fan_delay_flash,
   output logic                     dripping_active,
   output dfs_pkg::dfs_disp_t       display_code,
   output logic signed [15:0]       display_value
);
   // ----------------------------------------
   // Timers
   // ----------------------------------------
   logic [`DFS_NT-1:0] t_ld, t_busy, t_done;
   logic [`DFS_TW-1:0] t_val [`DFS_NT];

   genvar gi;
   generate
      for (gi = 0; gi < `DFS_NT; gi++) begin : g_tmr
         dfs_timer u_tmr (
            .clk      (clk),
            .sys_rst  (sys_rst),
            .clk_en   (clk_en),
            .tick     (time_tick),
            .load     (t_ld[gi]),
            .load_val (t_val[gi]),
            .busy     (t_busy[gi]),
            .done     (t_done[gi])
         );
      end
   endgenerate

   logic fan_ok;
   dfs_fan_window u_win (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .clk_en      (clk_en),
      .probe_valid (evap_probe_valid),
      .evap        (evaporator_probe),
      .high_cut    (fan_high_temp_cutoff),
      .low_cut     (fan_low_temp_cutoff),
      .hyst        (fan_cutoff_hysteresis),
      .fan_ok      (fan_ok)
   );

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   dfs_pkg::dfs_state_t state_r, state_nxt;
   dfs_pkg::dfs_disp_t  disp_r, disp_nxt;
   logic comp_r, comp_nxt, def_r, def_nxt, heat_r, heat_nxt;
   logic suct_r, suct_nxt, fan_r, fan_nxt, fhold_r, fhold_nxt;
   logic fcyc_r, fcyc_nxt, boot_r, boot_nxt, pwr_r, pwr_nxt;
   logic dlock_r, dlock_nxt, dpost_r, dpost_nxt;
   logic signed [15:0] dval_r, dval_nxt;
   logic chg, want, start_ok, fb, frz;
   logic signed [16:0] spd;

   // Hot-gas valve sequence only with suction on the aux output
   assign chg = defrost_type_select == `DFS_DT_CHG
             && aux_output_function == `DFS_AUX_SUCT;
   // Zero duration disables defrost altogether
   assign start_ok = defrost_start_req && defrost_max_duration != `DFS_T_OFF;
   assign want = cool_demand && pwr_r && (!chg || suct_r);
   assign spd = 17'(setpoint) + 17'(differential);
   assign frz = display_lock_select == `DFS_DL_FREEZE;

   always_comb begin
      state_nxt = state_r;
      comp_nxt  = comp_r;
      def_nxt   = def_r;
      heat_nxt  = heat_r;
      suct_nxt  = suct_r;
      fhold_nxt = fhold_r;
      fcyc_nxt  = fcyc_r;
      boot_nxt  = 1'b0;
      pwr_nxt   = pwr_r;
      dlock_nxt = dlock_r;
      dpost_nxt = dpost_r;
      t_ld      = '0;
      t_val[`DFS_T_PRE]   = pre_defrost_time;
      t_val[`DFS_T_DUR]   = defrost_max_duration;
      t_val[`DFS_T_DRIP]  = dripping_time;
      t_val[`DFS_T_POSTH] = post_defrost_heater_time;
      t_val[`DFS_T_EVAC]  = evacuation_delay;
      t_val[`DFS_T_LIQ]   = liquid_valve_start_delay;
      t_val[`DFS_T_PWR]   = power_on_output_delay;
      t_val[`DFS_T_FAND]  = post_defrost_fan_delay;
      t_val[`DFS_T_FCYC]  = fcyc_r ? fan_off_time_comp_off : fan_on_time_comp_off;
      t_val[`DFS_T_DISP]  = post_defrost_alarm_disable_time;

      // Power-up and, with centralized hot gas only, post-dripping restart share one delay
      if (boot_r)
         t_ld[`DFS_T_PWR] = 1'b1;
      if (t_done[`DFS_T_PWR]) begin
         pwr_nxt  = 1'b1;
         suct_nxt = chg && state_r != dfs_pkg::DFS_DEF;
      end
      if (t_done[`DFS_T_POSTH])
         heat_nxt = 1'b0;
      if (t_done[`DFS_T_FAND])
         fhold_nxt = 1'b0;

      unique case (state_r)
         dfs_pkg::DFS_IDLE: begin
            if (start_ok) begin
               comp_nxt  = 1'b0;
               dlock_nxt = display_lock_select != `DFS_DL_OFF;
               dpost_nxt = 1'b0;
               if (chg) begin
                  if (comp_r || t_busy[`DFS_T_EVAC]) begin
                     state_nxt = dfs_pkg::DFS_EVAC;
                  end else begin
                     // Evacuation already over: isolate now
                     suct_nxt  = 1'b0;
                     def_nxt   = 1'b1;
                     t_ld[`DFS_T_DUR] = 1'b1;
                     state_nxt = dfs_pkg::DFS_DEF;
                  end
               end else if (drain_heater_enable) begin
                  heat_nxt  = 1'b1;
                  t_ld[`DFS_T_PRE] = 1'b1;
                  state_nxt = dfs_pkg::DFS_PRE;
               end else begin
                  def_nxt   = 1'b1;
                  comp_nxt  = defrost_type_select != `DFS_DT_ELEC;
                  t_ld[`DFS_T_DUR] = 1'b1;
                  state_nxt = dfs_pkg::DFS_DEF;
               end
            end else if (!want) begin
               comp_nxt = 1'b0;
            end else if (!comp_r) begin
               if (t_done[`DFS_T_LIQ])
                  comp_nxt = 1'b1;
               else if (!t_busy[`DFS_T_LIQ])
                  t_ld[`DFS_T_LIQ] = 1'b1;
            end
         end
         dfs_pkg::DFS_PRE: begin
            if (t_done[`DFS_T_PRE]) begin
               def_nxt   = 1'b1;
               comp_nxt  = defrost_type_select != `DFS_DT_ELEC;
               t_ld[`DFS_T_DUR] = 1'b1;
               state_nxt = dfs_pkg::DFS_DEF;
            end
         end
         dfs_pkg::DFS_EVAC: begin
            if (t_done[`DFS_T_EVAC]) begin
               suct_nxt  = 1'b0;
               def_nxt   = 1'b1;
               t_ld[`DFS_T_DUR] = 1'b1;
               state_nxt = dfs_pkg::DFS_DEF;
            end
         end
         dfs_pkg::DFS_DEF: begin
            if (t_done[`DFS_T_DUR] || defrost_end_req) begin
               def_nxt   = 1'b0;
               comp_nxt  = 1'b0;
               fhold_nxt = !fans_during_defrost;
               dpost_nxt = dlock_r;
               t_ld[`DFS_T_DRIP] = 1'b1;
               t_ld[`DFS_T_FAND] = 1'b1;
               t_ld[`DFS_T_DISP] = 1'b1;
               t_ld[`DFS_T_POSTH] = heat_r;
               state_nxt = dfs_pkg::DFS_DRIP;
            end
         end
         dfs_pkg::DFS_DRIP: begin
            if (t_done[`DFS_T_DRIP]) begin
               // Compressor returns through the regulation path
               t_ld[`DFS_T_PWR] = chg;
               state_nxt = dfs_pkg::DFS_IDLE;
            end
         end
         default: state_nxt = dfs_pkg::DFS_IDLE;
      endcase

      // Fan on/off cycling while the compressor rests
      if (t_done[`DFS_T_FCYC] && !comp_r) begin
         fcyc_nxt = !fcyc_r;
         t_ld[`DFS_T_FCYC] = 1'b1;
      end
      if (comp_r && !comp_nxt) begin
         t_ld[`DFS_T_EVAC] = chg;
         fcyc_nxt = 1'b1;
         t_val[`DFS_T_FCYC] = fan_on_time_comp_off;
         t_ld[`DFS_T_FCYC] = 1'b1;
      end

      // Display release after defrost
      if (dpost_r && (17'(cabinet_probe) <= 17'(display_lock_value)
                      || 17'(cabinet_probe) <= spd || t_done[`DFS_T_DISP])) begin
         dlock_nxt = 1'b0;
         dpost_nxt = 1'b0;
      end
   end

   // ----------------------------------------
   // Fan and display next values
   // ----------------------------------------
   always_comb begin
      // Next values keep the fan in step with the valves
      if (state_nxt == dfs_pkg::DFS_DEF || state_nxt == dfs_pkg::DFS_PRE)
         fb = fans_during_defrost;
      else if (state_nxt == dfs_pkg::DFS_EVAC)
         fb = 1'b1; // Helps the evaporator empty
      else if (fhold_nxt)
         fb = 1'b0;
      else if (comp_nxt)
         fb = 1'b1;
      else if (fan_on_time_comp_off == `DFS_T_OFF)
         fb = 1'b0;
      else if (fan_off_time_comp_off == `DFS_T_OFF)
         fb = 1'b1;
      else
         fb = fcyc_nxt;
      fan_nxt = fb && fan_ok;
      if (!dlock_r)
         disp_nxt = dfs_pkg::DFS_SHOW_LIVE;
      else if (frz)
         disp_nxt = dfs_pkg::DFS_SHOW_FROZEN;
      else if (dpost_r)
         disp_nxt = dfs_pkg::DFS_SHOW_POST;
      else
         disp_nxt = dfs_pkg::DFS_SHOW_DEF;
      dval_nxt = (dlock_r && frz) ? dval_r : cabinet_probe;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= dfs_pkg::DFS_IDLE;
         disp_r  <= dfs_pkg::DFS_SHOW_LIVE;
         comp_r  <= 1'b0;
         def_r   <= 1'b0;
         heat_r  <= 1'b0;
         suct_r  <= 1'b0;
         fan_r   <= 1'b0;
         fhold_r <= 1'b0;
         fcyc_r  <= 1'b0;
         boot_r  <= 1'b1;
         pwr_r   <= 1'b0;
         dlock_r <= 1'b0;
         dpost_r <= 1'b0;
         dval_r  <= 16'sh0000;
      end else if (clk_en) begin
         state_r <= state_nxt;
         disp_r  <= disp_nxt;
         comp_r  <= comp_nxt;
         def_r   <= def_nxt;
         heat_r  <= heat_nxt;
         suct_r  <= suct_nxt;
         fan_r   <= fan_nxt;
         fhold_r <= fhold_nxt;
         fcyc_r  <= fcyc_nxt;
         boot_r  <= boot_nxt;
         pwr_r   <= pwr_nxt;
         dlock_r <= dlock_nxt;
         dpost_r <= dpost_nxt;
         dval_r  <= dval_nxt;
      end
   end

   assign compressor_output   = comp_r;
   assign defrost_output      = def_r;
   assign drain_heater_output = heat_r;
   assign auxiliary_output    = suct_r;
   assign fan_output          = fan_r;
   assign fan_delay_flash     = fhold_r;
   assign dripping_active     = state_r == dfs_pkg::DFS_DRIP;
   assign display_code        = disp_r;
   assign display_value       = dval_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   heater_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && state_r == dfs_pkg::DFS_IDLE && start_ok && !chg && drain_heater_enable
      |=> heat_r && !comp_r && state_r == dfs_pkg::DFS_PRE)
      else $error("heater start sequence wrong");
   pre_expiry_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && state_r == dfs_pkg::DFS_PRE && t_done[`DFS_T_PRE]
      |=> def_r && comp_r == (defrost_type_select != `DFS_DT_ELEC))
      else $error("pre-defrost expiry outputs wrong");
   defrost_end_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && state_r == dfs_pkg::DFS_DEF && (t_done[`DFS_T_DUR] || defrost_end_req)
      |=> !def_r && !comp_r && dripping_active)
      else $error("defrost end outputs wrong");
   drip_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      dripping_active |-> !comp_r)
      else $error("compressor on while dripping");
   hotgas_only_a: assert property (@(posedge clk) disable iff (sys_rst)
      chg && state_r == dfs_pkg::DFS_DEF |-> !comp_r && !suct_r && def_r)
      else $error("valve active beside hot gas");
   liquid_close_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && chg && state_r == dfs_pkg::DFS_IDLE && start_ok |=> !comp_r)
      else $error("liquid valve not closed");
   evac_expiry_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && state_r == dfs_pkg::DFS_EVAC && t_done[`DFS_T_EVAC]
      |=> !suct_r && def_r && (fans_during_defrost || !fan_r))
      else $error("evacuation expiry wrong");
   fan_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && state_nxt == dfs_pkg::DFS_IDLE && !comp_nxt
      && fan_on_time_comp_off == `DFS_T_OFF |=> !fan_r)
      else $error("fan runs with compressor off");
   fan_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && fhold_nxt
      && (state_nxt == dfs_pkg::DFS_DRIP || state_nxt == dfs_pkg::DFS_IDLE) |=> !fan_r)
      else $error("fan on during post-defrost delay");
endmodule : dfs_sequencer

// ===== verilog/dfs_regs.svh
// Constants of the defrost and fan sequencer
`ifndef DFS_REGS_SVH
`define DFS_REGS_SVH
// ----------------------------------------
// Widths and timer count
// ----------------------------------------
`define DFS_TW        16
`define DFS_NT        10
// ----------------------------------------
// Timer slots
// ----------------------------------------
`define DFS_T_PRE     0
`define DFS_T_DUR     1
`define DFS_T_DRIP    2
`define DFS_T_POSTH   3
`define DFS_T_EVAC    4
`define DFS_T_LIQ     5
`define DFS_T_PWR     6
`define DFS_T_FAND    7
`define DFS_T_FCYC    8
`define DFS_T_DISP    9
// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define DFS_T_OFF     16'h0000
`define DFS_AUX_SUCT  4'h3
`define DFS_DT_ELEC   2'h0
`define DFS_DT_HGAS   2'h1
`define DFS_DT_INV    2'h2
`define DFS_DT_CHG    2'h3
`define DFS_DL_OFF    2'h0
`define DFS_DL_FREEZE 2'h1
`define DFS_DL_LABEL  2'h2
`endif

// ===== verilog/dfs_pkg.sv
// Types of the defrost and fan sequencer
package dfs_pkg;
   typedef enum logic [4:0] {
      DFS_IDLE = 5'h01,
      DFS_PRE  = 5'h02,
      DFS_EVAC = 5'h04,
      DFS_DEF  = 5'h08,
      DFS_DRIP = 5'h10
   } dfs_state_t;
   typedef enum logic [1:0] {
      DFS_SHOW_LIVE   = 2'h0,
      DFS_SHOW_FROZEN = 2'h1,
      DFS_SHOW_DEF    = 2'h2,
      DFS_SHOW_POST   = 2'h3
   } dfs_disp_t;
endpackage : dfs_pkg

// ===== verilog/dfs_timer.sv
// Programmable delay counter on the common time-base tick
`timescale 1ns/10ps
`include "dfs_regs.svh"
module dfs_timer (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                clk_en,
   input  wire logic                tick,
   input  wire logic                load,
   input  wire logic [`DFS_TW-1:0]  load_val,
   output logic                     busy,
   output logic                     done
);
   logic [`DFS_TW-1:0] count_r, count_nxt;
   logic               arm_r, arm_nxt, done_r, done_nxt;

   // A zero load means off: done follows two cycles after the load
   always_comb begin
      count_nxt = count_r;
      arm_nxt   = arm_r;
      done_nxt  = 1'b0;
      if (load) begin
         count_nxt = load_val;
         arm_nxt   = 1'b1;
      end else if (arm_r && count_r == `DFS_T_OFF) begin
         arm_nxt  = 1'b0;
         done_nxt = 1'b1;
      end else if (arm_r && tick) begin
         count_nxt = count_r - 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= `DFS_T_OFF;
         arm_r   <= 1'b0;
         done_r  <= 1'b0;
      end else if (clk_en) begin
         count_r <= count_nxt;
         arm_r   <= arm_nxt;
         done_r  <= done_nxt;
      end
   end

   assign busy = arm_r;
   assign done = done_r;
endmodule : dfs_timer

// ===== verilog/dfs_fan_window.sv
// Evaporator temperature window with hysteresis for the fans
`timescale 1ns/10ps
module dfs_fan_window (
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire logic               clk_en,
   input  wire logic               probe_valid,
   input  wire logic signed [15:0] evap,
   input  wire logic signed [15:0] high_cut,
   input  wire logic signed [15:0] low_cut,
   input  wire logic signed [15:0] hyst,
   output logic                    fan_ok
);
   logic signed [16:0] ev, hi_off, lo_on;
   logic               hot_r, hot_nxt, cold_r, cold_nxt;

   assign ev     = 17'(evap);
   assign hi_off = 17'(high_cut) - 17'(hyst);
   assign lo_on  = 17'(low_cut) + 17'(hyst);

   always_comb begin
      hot_nxt  = hot_r;
      cold_nxt = cold_r;
      if (ev > 17'(high_cut))
         hot_nxt = 1'b1;
      else if (ev < hi_off)
         hot_nxt = 1'b0;
      if (ev < 17'(low_cut))
         cold_nxt = 1'b1;
      else if (ev > lo_on)
         cold_nxt = 1'b0;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hot_r  <= 1'b0;
         cold_r <= 1'b0;
      end else if (clk_en) begin
         hot_r  <= hot_nxt;
         cold_r <= cold_nxt;
      end
   end

   // No valid probe: window never blocks
   assign fan_ok = !probe_valid || !(hot_r || cold_r);
endmodule : dfs_fan_window

// ===== tb/dfs_relay_bank.sv
// Relay bank model driven by the sequencer's control outputs
`timescale 1ns/10ps
module dfs_relay_bank (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic liquid_coil,
   input  wire logic hotgas_coil,
   input  wire logic heater_coil,
   input  wire logic suction_coil,
   input  wire logic fan_coil,
   output logic      liquid_on,
   output logic      hotgas_on,
   output logic      heater_on,
   output logic      suction_on,
   output logic      fan_on,
   output int        comp_starts
);
   // Contacts follow their coils; bounce is not modelled
   assign liquid_on  = liquid_coil;
   assign hotgas_on  = hotgas_coil;
   assign heater_on  = heater_coil;
   assign suction_on = suction_coil;
   assign fan_on     = fan_coil;
   logic liquid_q;
   // Start count shows relay wear per run
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         comp_starts <= 0;
         liquid_q    <= 1'b0;
      end else begin
         liquid_q <= liquid_coil;
         if (liquid_coil && !liquid_q)
            comp_starts <= comp_starts + 1;
      end
   end
endmodule : dfs_relay_bank

// ===== tb/test_defrost_fan_sequencer.sv
// Self-checking bench of the defrost and fan sequencer
`timescale 1ns/10ps
`include "dfs_regs.svh"
module test_defrost_fan_sequencer;
   logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, time_tick = 1'b0;
   logic cool_demand = 1'b1, defrost_start_req = 1'b0, defrost_end_req = 1'b0;
   logic [1:0] display_lock_select = `DFS_DL_LABEL, defrost_type_select = `DFS_DT_ELEC;
   logic [3:0] aux_output_function = `DFS_AUX_SUCT;
   logic drain_heater_enable = 1'b1, fans_during_defrost = 1'b0, evap_probe_valid = 1'b1;
   logic signed [15:0] cabinet_probe = 16'h0032, evaporator_probe = 16'h0000;
   logic signed [15:0] display_lock_value = 16'h0000, setpoint = 16'h0000;
   logic signed [15:0] differential = 16'h0002, fan_high_temp_cutoff = 16'h0064;
   logic signed [15:0] fan_low_temp_cutoff = 16'hFF9C, fan_cutoff_hysteresis = 16'h0002;
   logic [15:0] post_defrost_alarm_disable_time = 16'h0014, pre_defrost_time = 16'h0003;
   logic [15:0] post_defrost_heater_time = 16'h000C, defrost_max_duration = 16'h0004;
   logic [15:0] dripping_time = 16'h0003, power_on_output_delay = 16'h0002;
   logic [15:0] liquid_valve_start_delay = 16'h0001, evacuation_delay = 16'h0004;
   logic [15:0] post_defrost_fan_delay = 16'h0003, fan_on_time_comp_off = 16'h0005;
   logic [15:0] fan_off_time_comp_off = 16'h0000;
   logic compressor_output, defrost_output, drain_heater_output, auxiliary_output;
   logic fan_output, fan_delay_flash, dripping_active;
   logic liquid_on, hotgas_on, heater_on, suction_on, fan_on;
   dfs_pkg::dfs_disp_t display_code;
   logic signed [15:0] display_value;
   int fails = 0, tests_run = 0, cycles = 0, waited, comp_starts;

   dfs_sequencer i_dut (.clk, .sys_rst, .clk_en, .time_tick, .cool_demand, .defrost_start_req,
      .defrost_end_req, .display_lock_select, .defrost_type_select, .aux_output_function,
      .drain_heater_enable, .fans_during_defrost, .evap_probe_valid, .cabinet_probe,
      .evaporator_probe, .display_lock_value, .setpoint, .differential, .fan_high_temp_cutoff,
      .fan_low_temp_cutoff, .fan_cutoff_hysteresis, .post_defrost_alarm_disable_time,
      .pre_defrost_time, .post_defrost_heater_time, .defrost_max_duration, .dripping_time,
      .power_on_output_delay, .liquid_valve_start_delay, .evacuation_delay,
      .post_defrost_fan_delay, .fan_on_time_comp_off, .fan_off_time_comp_off,
      .compressor_output, .defrost_output, .drain_heater_output, .auxiliary_output,
      .fan_output, .fan_delay_flash, .dripping_active, .display_code, .display_value);

   dfs_relay_bank i_relays (.clk, .sys_rst, .liquid_coil(compressor_output),
      .hotgas_coil(defrost_output), .heater_coil(drain_heater_output),
      .suction_coil(auxiliary_output), .fan_coil(fan_output), .liquid_on, .hotgas_on,
      .heater_on, .suction_on, .fan_on, .comp_starts);

   always #4 clk = ~clk;
   // Tick every other cycle so each delay spans a measurable window
   always @(posedge clk) begin
      time_tick <= #1 ~time_tick;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         $display("unexpected %0t run timed out", $time);
         summarize();
      end
   end

   function automatic logic rel(int s);
      case (s)
         0: rel = liquid_on;
         1: rel = hotgas_on;
         2: rel = heater_on;
         3: rel = suction_on;
         4: rel = fan_on;
         5: rel = fan_delay_flash;
         default: rel = dripping_active;
      endcase
   endfunction : rel

   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic chk(logic got, logic exp, string m);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask : chk

   // Bounded wait for a relay or status output state, then judged
   task automatic wt(int s, logic v, int n);
      waited = 0;
      while (rel(s) !== v && waited < n) begin
         cyc(1);
         waited++;
      end
      chk(rel(s), v, "output did not settle in time");
   endtask : wt

   task automatic do_reset;
      sys_rst = 1'b1;
      cyc(5);
      sys_rst = 1'b0;
   endtask : do_reset

   task automatic pulse(input bit e);
      if (e) defrost_end_req = 1'b1;
      else defrost_start_req = 1'b1;
      cyc(1);
      defrost_end_req = 1'b0;
      defrost_start_req = 1'b0;
   endtask : pulse

   task automatic t_heater_defrost(logic [1:0] ty);
      dfs_pkg::dfs_disp_t dl, pl;
      dl = (ty == 2'h1) ? dfs_pkg::DFS_SHOW_FROZEN : dfs_pkg::DFS_SHOW_DEF;
      pl = (ty == 2'h1) ? dfs_pkg::DFS_SHOW_FROZEN : dfs_pkg::DFS_SHOW_POST;
      defrost_type_select = ty;
      display_lock_select = (ty == 2'h1) ? `DFS_DL_FREEZE : `DFS_DL_LABEL;
      cabinet_probe = 16'sh0032;
      do_reset();
      wt(0, 1'b1, 60);
      pulse(1'b0);
      wt(0, 1'b0, 2);
      chk(heater_on, 1'b1, "heater not on at start");
      wt(1, 1'b1, 20);
      chk(waited >= 4, 1'b1, "pre time too short");
      wt(0, ty != `DFS_DT_ELEC, 8);
      chk(display_code === dl, 1'b1, "wrong defrost display");
      cabinet_probe = 16'sh0040;
      wt(1, 1'b0, 20);
      cyc(1);
      chk(liquid_on, 1'b0, "compressor on after duration");
      chk(dripping_active, 1'b1, "no dripping");
      chk(display_code === pl, 1'b1, "wrong post-defrost display");
      chk(display_value === (ty == 2'h1 ? 16'sh0032 : 16'sh0040), 1'b1, "display value");
      wt(6, 1'b0, 20);
      chk(heater_on, 1'b1, "heater dropped early");
      wt(0, 1'b1, 20);
      wt(2, 1'b0, 40);
      chk(comp_starts == (ty == 2'h0 ? 2 : 3), 1'b1, "relay start count");
      $display("test heater defrost type %0d done", ty);
   endtask : t_heater_defrost

   task automatic t_central;
      defrost_type_select = `DFS_DT_CHG;
      do_reset();
      wt(3, 1'b1, 20);
      chk(liquid_on, 1'b0, "liquid before suction");
      wt(0, 1'b1, 20);
      pulse(1'b0);
      wt(0, 1'b0, 2);
      chk(suction_on & fan_on, 1'b1, "evacuation outputs");
      wt(3, 1'b0, 30);
      chk(waited >= 4, 1'b1, "evacuation too short");
      wt(1, 1'b1, 2);
      chk(liquid_on | suction_on | fan_on, 1'b0, "valve open in hot gas");
      cyc(4);
      pulse(1'b1);
      wt(1, 1'b0, 3);
      wt(5, 1'b1, 3);
      wt(3, 1'b1, 30);
      chk(liquid_on, 1'b0, "liquid with suction");
      wt(0, 1'b1, 20);
      wt(4, 1'b1, 30);
      cool_demand = 1'b0;
      wt(0, 1'b0, 10);
      cyc(40);
      chk(fan_on, 1'b1, "fan stopped with off time off");
      pulse(1'b0);
      wt(3, 1'b0, 3);
      wt(1, 1'b1, 3);
      evaporator_probe = 16'h00C8;
      pulse(1'b1);
      wt(3, 1'b1, 40);
      cyc(20);
      chk(fan_on, 1'b0, "fan on above high cutoff");
      evaporator_probe = 16'h0000;
      wt(4, 1'b1, 10);
      fan_on_time_comp_off = 16'h0000;
      cool_demand = 1'b1;
      wt(0, 1'b1, 40);
      cool_demand = 1'b0;
      wt(0, 1'b0, 10);
      wt(4, 1'b0, 3);
      chk(comp_starts == 3, 1'b1, "relay start count");
      $display("test centralized hot gas done");
   endtask : t_central

   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize

   initial begin
      for (int t = 0; t < 3; t++) t_heater_defrost(2'(t));
      t_central();
      summarize();
   end
endmodule : test_defrost_fan_sequencer
